// [core/acs_pkg.sv]
// constants, register map and types shared by the chip-select serial readout host
// assumes a 100 MHz REF_CLK and a zero-wait APB slave port
package acs_pkg;

    // ****************************************
    // clock and pin timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CNV_PULSE_NS = 20;
    localparam int CONV_MAX_NS = 500;
    localparam int QUIET1_NS = 60;
    localparam int QUIET2_NS = 60;
    localparam int BUSY_MARGIN_NS = 200;
    // a pulse that must end early rounds down, a wait rounds up
    localparam int CNV_PULSE_CYC = (CNV_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (CNV_PULSE_NS / CLK_PERIOD_NS);
    localparam int CONV_MAX_CYC = (CONV_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUIET1_CYC = (QUIET1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUIET2_CYC = (QUIET2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_TIMEOUT_CYC = CONV_MAX_CYC +
        (BUSY_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_CYC = 4;
    localparam int CNT_W = 10;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_STAT_EN_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_TMO_BIT = 2;
    localparam int STAT_PREV_BIT = 3;
    localparam int STAT_DEV_LSB = 4;
    // device status word layout
    localparam int DEV_OV_CLAMP_BIT = 5;
    localparam int DEV_SPAN_BIT = 4;
    localparam int DEV_HIZ_BIT = 3;
    localparam int DEV_PREV_EN_BIT = 2;
    localparam logic [31:0] REG_RST = 32'h0;

    typedef enum logic [1:0] {
        MODE_3W_BUSY,
        MODE_4W_PREV,
        MODE_4W_NOBUSY,
        MODE_4W_BUSY
    } acs_mode_t;

endpackage

// [core/acs_host.sv]
// host controller for a 16-bit converter read out in chip-select modes
// assumes a pull-up on the result line and one converter on the select line
`timescale 1ns/1ps

module acs_host #(
    parameter int RESULT_BITS = 16,
    parameter int STATUS_BITS = 6
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic CONVERSION_TRIGGER,
    output logic SERIAL_IN_SELECT,
    output logic SERIAL_CLOCK,
    input wire logic SERIAL_RESULT_OUT
);
    import acs_pkg::*;

    localparam int SH_W = RESULT_BITS + STATUS_BITS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TRIG,
        ST_CONV,
        ST_SHIFT,
        ST_FINISH,
        ST_QUIET
    } acs_state_t;

    function automatic logic is_busy(input acs_mode_t m);
        is_busy = (m == MODE_3W_BUSY) || (m == MODE_4W_BUSY);
    endfunction

    function automatic logic [4:0] frame_pulses(input acs_mode_t m, input logic st_en);
        logic [4:0] n;
        n = st_en ? 5'(SH_W) : 5'(RESULT_BITS);
        // busy modes get one more pulse: its falling edge puts out the first bit
        frame_pulses = is_busy(m) ? n + 5'h01 : n;
    endfunction

    // ****************************************
    // signals
    // ****************************************
    acs_state_t state_reg;
    acs_mode_t mode_reg;
    acs_mode_t frame_mode_reg;
    logic stat_en_reg;
    logic frame_stat_reg;
    logic start_reg;
    logic cnv_reg;
    logic sdi_reg;
    logic sck_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [2:0] phase_reg;
    logic [4:0] pulse_reg;
    logic [SH_W-1:0] shift_reg;
    logic [RESULT_BITS-1:0] result_reg;
    logic [STATUS_BITS-1:0] dev_stat_reg;
    logic done_reg;
    logic tmo_reg;
    logic prev_reg;
    logic sdo_meta_reg;
    logic sdo_sync_reg;
    logic [31:0] prdata_reg;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic half_end;
    logic shift_done;
    logic conv_timeout;

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    assign addr_ok = (PADDR == OFS_CTRL) || (PADDR == OFS_STATUS) || (PADDR == OFS_DATA);
    assign half_end = (phase_reg == 3'(SCK_HALF_CYC - 1));
    assign shift_done = (state_reg == ST_SHIFT) && half_end && sck_reg &&
        (pulse_reg + 5'h01 == frame_pulses(frame_mode_reg, frame_stat_reg));
    assign conv_timeout = (state_reg == ST_CONV) && is_busy(frame_mode_reg) &&
        sdo_sync_reg && (cnt_reg >= CNT_W'(BUSY_TIMEOUT_CYC));

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign PRDATA = prdata_reg;
    assign CONVERSION_TRIGGER = cnv_reg;
    assign SERIAL_IN_SELECT = sdi_reg;
    assign SERIAL_CLOCK = sck_reg;

    // ****************************************
    // result line synchroniser
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sdo_meta_reg <= 1'b1;
            sdo_sync_reg <= 1'b1;
        end else begin
            sdo_meta_reg <= SERIAL_RESULT_OUT;
            sdo_sync_reg <= sdo_meta_reg;
        end
    end

    // ****************************************
    // apb registers
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mode_reg <= MODE_3W_BUSY;
            stat_en_reg <= REG_RST[0];
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (wr_en && PADDR == OFS_CTRL) begin
                // selecting previous-result mode drops the busy handshake
                mode_reg <= acs_mode_t'(PWDATA[CTRL_MODE_LSB +: 2]);
                stat_en_reg <= PWDATA[CTRL_STAT_EN_BIT];
                start_reg <= PWDATA[CTRL_START_BIT];
            end
        end
    end

    // read data is prepared in the setup cycle so the access cycle needs no wait
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            prdata_reg <= REG_RST;
        end else if (rd_setup) begin
            prdata_reg <= REG_RST;
            case (PADDR)
                OFS_CTRL: begin
                    prdata_reg[CTRL_MODE_LSB +: 2] <= mode_reg;
                    prdata_reg[CTRL_STAT_EN_BIT] <= stat_en_reg;
                end
                OFS_STATUS: begin
                    prdata_reg[STAT_BUSY_BIT] <= (state_reg != ST_IDLE);
                    prdata_reg[STAT_DONE_BIT] <= done_reg;
                    prdata_reg[STAT_TMO_BIT] <= tmo_reg;
                    prdata_reg[STAT_PREV_BIT] <= prev_reg;
                    prdata_reg[STAT_DEV_LSB +: STATUS_BITS] <= dev_stat_reg;
                end
                OFS_DATA: begin
                    prdata_reg[RESULT_BITS-1:0] <= result_reg;
                end
                default: begin
                    prdata_reg <= REG_RST;
                end
            endcase
        end
    end

    // ****************************************
    // frame sequencer and pins
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            frame_mode_reg <= MODE_3W_BUSY;
            frame_stat_reg <= 1'b0;
            cnv_reg <= 1'b0;
            sdi_reg <= 1'b1;
            cnt_reg <= '0;
        end else begin
            if (cnt_reg != '1) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            case (state_reg)
                ST_IDLE: begin
                    // start requests while a frame runs are dropped
                    if (start_reg) begin
                        frame_mode_reg <= mode_reg;
                        frame_stat_reg <= stat_en_reg;
                        cnv_reg <= 1'b1;
                        sdi_reg <= 1'b1;
                        cnt_reg <= '0;
                        state_reg <= ST_TRIG;
                    end
                end
                ST_TRIG: begin
                    if (cnt_reg >= CNT_W'(CNV_PULSE_CYC - 1)) begin
                        case (frame_mode_reg)
                            MODE_3W_BUSY: cnv_reg <= 1'b0;
                            MODE_4W_BUSY: sdi_reg <= 1'b0;
                            default: sdi_reg <= 1'b1;
                        endcase
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    case (frame_mode_reg)
                        MODE_4W_PREV: begin
                            // select falls after the quiet time
                            if (cnt_reg >= CNT_W'(QUIET1_CYC)) begin
                                sdi_reg <= 1'b0;
                                state_reg <= ST_SHIFT;
                            end
                        end
                        MODE_4W_NOBUSY: begin
                            // no clock until the longest conversion is over
                            if (cnt_reg >= CNT_W'(CONV_MAX_CYC)) begin
                                sdi_reg <= 1'b0;
                                state_reg <= ST_SHIFT;
                            end
                        end
                        default: begin
                            // the low level on the pulled-up line ends the wait
                            if (!sdo_sync_reg) begin
                                state_reg <= ST_SHIFT;
                            end else if (conv_timeout) begin
                                state_reg <= ST_FINISH;
                            end
                        end
                    endcase
                end
                ST_SHIFT: begin
                    if (shift_done) begin
                        state_reg <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    // in 4-wire frames the trigger stays high until the conversion that it started is over
                    if (cnt_reg >= CNT_W'(CONV_MAX_CYC)) begin
                        cnv_reg <= 1'b0;
                        sdi_reg <= 1'b1; // released at once, no overlap
                        cnt_reg <= '0;
                        state_reg <= ST_QUIET;
                    end
                end
                ST_QUIET: begin
                    if (cnt_reg >= CNT_W'(QUIET2_CYC)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // serial clock and bit capture
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sck_reg <= 1'b0;
            phase_reg <= '0;
            pulse_reg <= '0;
            shift_reg <= '0;
        end else if (state_reg != ST_SHIFT) begin
            sck_reg <= 1'b0;
            phase_reg <= '0;
            pulse_reg <= '0;
        end else if (half_end) begin
            phase_reg <= '0;
            sck_reg <= !sck_reg;
            if (sck_reg) begin
                pulse_reg <= pulse_reg + 5'h01; // busy frames add one pulse
                // sampled at the end of the high phase, the bit has stood a full half period
                if (!is_busy(frame_mode_reg) || pulse_reg != 5'h00) begin
                    shift_reg <= {shift_reg[SH_W-2:0], sdo_sync_reg};
                end
            end
        end else begin
            phase_reg <= phase_reg + 3'h1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            result_reg <= '0;
            dev_stat_reg <= '0;
            done_reg <= 1'b0;
            tmo_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            if (wr_en && PADDR == OFS_STATUS) begin
                done_reg <= done_reg && !PWDATA[STAT_DONE_BIT];
                tmo_reg <= tmo_reg && !PWDATA[STAT_TMO_BIT];
            end
            // a completing frame wins over a clear in the same cycle
            if (state_reg == ST_SHIFT && state_reg != ST_IDLE && shift_done) begin
                done_reg <= 1'b1;
                prev_reg <= (frame_mode_reg == MODE_4W_PREV);
                if (frame_stat_reg) begin
                    // the last sample is still entering the register
                    result_reg <= shift_reg[SH_W-2:STATUS_BITS-1];
                    dev_stat_reg <= {shift_reg[STATUS_BITS-2:0], sdo_sync_reg};
                end else begin
                    result_reg <= {shift_reg[RESULT_BITS-2:0], sdo_sync_reg};
                end
            end
            if (conv_timeout) begin
                tmo_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [CNT_W-1:0] gap_reg;
    always_ff @(posedge REF_CLK) begin
        if (RST || (sck_reg && half_end && state_reg == ST_SHIFT)) begin
            gap_reg <= '0;
        end else if (gap_reg != '1) begin
            gap_reg <= gap_reg + 1'b1;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    a_quiet_clock_conv: assert property (state_reg == ST_CONV |-> !sck_reg)
        else $error("serial clock toggled during conversion");
    a_sdi_high_rise: assert property ($rose(cnv_reg) |-> sdi_reg)
        else $error("select low at trigger rise");
    a_cnv_low_3w: assert property ((state_reg == ST_TRIG && frame_mode_reg == MODE_3W_BUSY)
        |-> ##[1:2] !cnv_reg)
        else $error("trigger not returned low in 3-wire busy frame");
    a_cnv_high_4w: assert property ((frame_mode_reg != MODE_3W_BUSY
        && state_reg inside {ST_CONV, ST_SHIFT}) |-> cnv_reg)
        else $error("trigger dropped during 4-wire frame");
    a_sdi_busy_low: assert property ((state_reg == ST_CONV && frame_mode_reg == MODE_4W_BUSY)
        |-> !sdi_reg)
        else $error("select high while waiting for busy indication");
    a_sdi_nobusy_high: assert property ((state_reg == ST_CONV
        && frame_mode_reg == MODE_4W_NOBUSY) |-> sdi_reg)
        else $error("select low during no-busy conversion");
    a_sdi_3w_high: assert property ((frame_mode_reg == MODE_3W_BUSY
        && state_reg != ST_IDLE) |-> sdi_reg)
        else $error("select low in 3-wire frame");
    a_quiet1_wait: assert property (($fell(sdi_reg) && frame_mode_reg == MODE_4W_PREV)
        |-> $past(cnt_reg) >= CNT_W'(QUIET1_CYC))
        else $error("select fell before first quiet interval");
    a_quiet2_gap: assert property ($rose(cnv_reg) |-> gap_reg > CNT_W'(QUIET2_CYC))
        else $error("trigger rose too soon after last clock fall");
    a_pulse_count: assert property ((state_reg == ST_SHIFT) ##1 (state_reg == ST_FINISH)
        |-> pulse_reg == frame_pulses(frame_mode_reg, frame_stat_reg))
        else $error("wrong number of clock pulses in frame");
    a_mode_reset: assert property ($fell(RST) |-> mode_reg == MODE_3W_BUSY)
        else $error("previous-result mode not off after reset");

    c_frame_3w_busy: cover property (state_reg == ST_SHIFT && frame_mode_reg == MODE_3W_BUSY
        ##1 state_reg == ST_FINISH);
    c_frame_prev: cover property (state_reg == ST_SHIFT && frame_mode_reg == MODE_4W_PREV
        ##1 state_reg == ST_FINISH);
    c_frame_status: cover property (shift_done && frame_stat_reg);
    c_busy_timeout: cover property (conv_timeout);

endmodule

// [dv/acs_conv_model.sv]
// behavioural converter on the far side of the chip-select readout host
// assumes a pull-up on the result line and one converter on the select line
`timescale 1ns/1ps
module acs_conv_model
import acs_pkg::*;
#(
    parameter int CONV_MIN_NS = 100
) (
    input wire logic conversion_trigger,
    input wire logic serial_in_select,
    input wire logic serial_clock,
    output logic serial_result_out,
    input wire acs_mode_t mode,
    input wire logic stat_en,
    input wire logic mute,
    input wire logic [15:0] sample,
    input wire logic [2:0] flags,
    input wire logic [9:0] conv_ns,
    output logic [7:0] viol
);
    // ****************************************
    // conversion, busy low and shift-out
    // ****************************************
    logic drv = 1'b0;
    logic bitv = 1'b0;
    logic converting = 1'b0;
    logic [15:0] last_res = 16'h0;
    logic [21:0] sh = 22'h0;
    int n = 0;
    int nmax = 16;
    realtime t_trig = 0.0;
    realtime t_fall = -1000.0;
    initial viol = 8'h0;
    // released line reads high through the pull-up; a lone device, no contention
    assign serial_result_out = drv ? bitv : 1'b1;
    always @(posedge conversion_trigger) begin
        if (mode != MODE_3W_BUSY && serial_in_select !== 1'b1) viol++;
        if ($realtime - t_fall < QUIET2_NS) viol++;
        drv = 1'b0;
        t_trig = $realtime;
        // status word: three flags, previous-result enable, two reserved zeros
        sh = {(mode == MODE_4W_PREV) ? last_res : sample, flags, mode == MODE_4W_PREV,
            2'b00};
        last_res = sample;
        nmax = stat_en ? 22 : 16;
        n = 0;
        converting = 1'b1;
        #(CONV_MIN_NS);
        if (mode == MODE_3W_BUSY && conversion_trigger) viol++;
        if (mode == MODE_4W_BUSY && serial_in_select) viol++;
        if (mode == MODE_4W_NOBUSY && !serial_in_select) viol++;
        #(conv_ns - CONV_MIN_NS);
        converting = 1'b0;
        if (!mute && (mode == MODE_3W_BUSY || (mode == MODE_4W_BUSY && !serial_in_select))) begin
            drv = 1'b1;
            bitv = 1'b0;
        end
    end
    always @(negedge conversion_trigger)
        if (converting && mode != MODE_3W_BUSY) viol++;
    // previous-result mode may clock during conversion, the others may not
    always @(serial_clock)
        if (converting && mode != MODE_4W_PREV) viol++;
    always @(negedge serial_in_select) begin
        if (mode == MODE_3W_BUSY) viol++;
        if (mode == MODE_4W_PREV && $realtime - t_trig < QUIET1_NS) viol++;
        if (mode == MODE_4W_PREV || mode == MODE_4W_NOBUSY) begin
            drv = 1'b1;
            bitv = sh[21];
            n = 1;
        end
    end
    always @(posedge serial_in_select)
        if (mode == MODE_4W_NOBUSY) drv = 1'b0;
    always @(negedge serial_clock) begin
        t_fall = $realtime;
        if (drv && n >= nmax) drv = 1'b0;
        else if (drv) begin
            bitv = sh[21 - n];
            n++;
        end
    end
endmodule

// [dv/test_acs_host.sv]
// self-checking bench: APB host side against the behavioural converter
// assumes acs_pkg, acs_host and acs_conv_model are compiled first
`timescale 1ns/1ps
module test_acs_host;
import acs_pkg::*;
    // ****************************************
    // clock, pins and bookkeeping
    // ****************************************
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, trig, sel, sclk, res_line;
    acs_mode_t md = MODE_3W_BUSY;
    logic stat_en = 1'b0;
    logic mute = 1'b0;
    logic [15:0] smp = 16'h0;
    logic [15:0] last_smp = 16'h0;
    logic [2:0] flags = 3'h0;
    logic [9:0] conv_ns = 10'd150;
    logic [7:0] viol;
    int errors = 0, cmp_count = 0, cyc = 0, trig_n = 0, sck_n = 0;
    initial forever #5 REF_CLK = ~REF_CLK;
    always @(posedge trig) trig_n++;
    always @(posedge sclk) sck_n++;
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    acs_host i_acs_host (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CONVERSION_TRIGGER(trig), .SERIAL_IN_SELECT(sel),
        .SERIAL_CLOCK(sclk), .SERIAL_RESULT_OUT(res_line));
    acs_conv_model i_acs_conv_model (.conversion_trigger(trig), .serial_in_select(sel),
        .serial_clock(sclk), .serial_result_out(res_line), .mode(md), .stat_en(stat_en),
        .mute(mute), .sample(smp), .flags(flags), .conv_ns(conv_ns), .viol(viol));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle edge after each transfer keeps drivers to one assignment per step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1) @(posedge REF_CLK);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic frame(input acs_mode_t m, input logic se, input logic [15:0] s,
            input logic two, output logic [31:0] st, output logic [31:0] dat);
        logic [31:0] q;
        logic e;
        int i;
        md <= m;
        stat_en <= se;
        smp <= s;
        apb(1'b1, OFS_CTRL, {28'h0, se, m, 1'b1}, q, e);
        if (two) apb(1'b1, OFS_CTRL, {28'h0, se, m, 1'b1}, q, e);
        i = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0, st, e);
            i++;
        end while (!(st[0] === 1'b0 && st[2:1] !== 2'b00) && i < 300);
        if (i >= 300) begin
            errors++;
            $display("Error at %0t: frame never finished", $time);
        end
        apb(1'b0, OFS_DATA, 32'h0, dat, e);
        apb(1'b1, OFS_STATUS, 32'h6, q, e);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        apb(1'b0, OFS_CTRL, 32'h0, q, e);
        chk(q, REG_RST);
        apb(1'b0, OFS_STATUS, 32'h0, q, e);
        chk(q, REG_RST);
        apb(1'b0, OFS_DATA, 32'h0, q, e);
        chk(q, REG_RST);
        apb(1'b1, 8'h10, 32'hffffffff, q, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h0c, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0, q, e);
        chk(q, REG_RST);
    endtask
    // every mode with status off and on, prompt and slow conversions
    task automatic t_modes();
        logic [31:0] st, dat;
        logic [15:0] tbl [8] = '{16'ha5c3, 16'h0001, 16'h8000, 16'hffff,
            16'h7ffe, 16'h1234, 16'hc0de, 16'h5aa5};
        int n0;
        for (int k = 0; k < 8; k++) begin
            flags <= 3'(k + 3);
            conv_ns <= k[0] ? 10'd450 : 10'd150;
            n0 = sck_n;
            frame(acs_mode_t'(k[2:1]), k[0], tbl[k], 1'b0, st, dat);
            chk(dat, {16'h0, (k[2:1] == 1) ? last_smp : tbl[k]});
            chk(st[3:1], {k[2:1] == 1, 2'b01});
            chk(sck_n - n0, (k[0] ? 22 : 16) + (k[2:1] != 1 && k[2:1] != 2));
            if (k[0]) chk(st[9:4], {3'(k + 3), k[2:1] == 1, 2'b00});
            chk(viol, 0);
            last_smp = tbl[k];
        end
    endtask
    task automatic t_timeout();
        logic [31:0] st, dat;
        mute <= 1'b1;
        frame(MODE_3W_BUSY, 1'b0, 16'h3c3c, 1'b0, st, dat);
        chk(st[2], 1'b1);
        chk(dat, {16'h0, last_smp});
        mute <= 1'b0;
        last_smp = 16'h3c3c;
    endtask
    task automatic t_double();
        logic [31:0] st, dat;
        int t0;
        t0 = trig_n;
        frame(MODE_4W_NOBUSY, 1'b0, 16'h0ff0, 1'b1, st, dat);
        chk(trig_n - t0, 1);
        chk(dat, 32'h0ff0);
        chk(viol, 0);
    endtask
    initial begin
        repeat (20) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        t_regs();
        t_modes();
        t_timeout();
        t_double();
        wrap_up();
    end
endmodule
